// File: inc/rsc_cfg.svh
// Offsets, field positions, reset values and timing counts of the reset controller
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define RSC_OFF_MON_CTRL 8'h00
`define RSC_OFF_CAUSE 8'h04
`define RSC_OFF_MASK 8'hfc

// ------------------------------------------------------------------
// Supply monitor control fields
// ------------------------------------------------------------------
`define RSC_MON_ON_BIT 7
`define RSC_MON_STAT_BIT 6
`define RSC_MON_HIGH_BIT 5

// ------------------------------------------------------------------
// Reset cause fields
// ------------------------------------------------------------------
`define RSC_CAUSE_PIN_BIT 0
`define RSC_CAUSE_POR_BIT 1
`define RSC_CAUSE_EXT_BIT 2
`define RSC_CAUSE_SW_BIT 4
`define RSC_CAUSE_FLASH_BIT 6

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RSC_MON_ON_RST 1'b1
`define RSC_MON_HIGH_RST 1'b0
`define RSC_MON_SEL_RST 1'b1
`define RSC_PORT_LATCH_RST 8'hff
`define RSC_PC_RST 16'h0000
`define RSC_WDT_DIV 4'hc
`define RSC_WORD_ZERO 32'h0000_0000

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define RSC_CLK_NS 100
`define RSC_POR_DELAY_US 100
`define RSC_POR_DELAY_CYC ((`RSC_POR_DELAY_US * 1000 + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_CNT_W 12

`endif

// File: inc/rsc_pkg.sv
// Types shared by the reset controller files
package rsc_pkg;

  // ------------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [4:0]
  {
    RSC_POR_WAIT = 5'b00001,
    RSC_POR_DELAY = 5'b00010,
    RSC_RUN = 5'b00100,
    RSC_HOLD = 5'b01000,
    RSC_LOCK = 5'b10000
  } rsc_state_t;

endpackage

// File: design/rsc_rst_sync.sv
// Reset release synchroniser for the core
`timescale 1ns/1ps

module rsc_rst_sync
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request and synchronised reset
  input wire logic rst_req,
  output logic rst_n_out
);

  logic stage1_reg;
  logic stage2_reg;

  // ------------------------------------------------------------------
  // Fast assert, two-stage release
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end
    else
    begin
      stage1_reg <= ~rst_req;
      stage2_reg <= stage1_reg & ~rst_req;
    end
  end

  assign rst_n_out = stage2_reg;

endmodule // rsc_rst_sync

// File: design/rsc_reset_source_controller.sv
// Reset source controller: sequencer, supply monitor state, cause flags, AHB-Lite slave
`timescale 1ns/1ps
`include "rsc_cfg.svh"

module rsc_reset_source_controller
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Supply monitor and regulator
  input wire logic supply_above,
  input wire logic reg_uncal_low,
  output logic supply_monitor_on,
  output logic supply_threshold_high,
  output logic reg_cal_start,
  // Other reset sources
  input wire logic ext_rst_req,
  input wire logic flash_op,
  // Reset pin
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe_n,
  // Core side
  output logic core_rst_n,
  output logic core_halt,
  output logic sfr_load,
  output logic int_timer_off,
  output logic sp_reload,
  output logic ram_keep,
  output logic [7:0] port_latch,
  output logic port_open_drain,
  output logic weak_pullup_en,
  output logic pc_clear,
  output logic [15:0] pc_value,
  output logic clk_sel_int,
  output logic wdt_en,
  output logic [3:0] wdt_div
);

  localparam logic [`RSC_CNT_W-1:0] POR_LAST = `RSC_CNT_W'(`RSC_POR_DELAY_CYC - 1);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  rsc_pkg::rsc_state_t state_reg, state_next;
  logic [`RSC_CNT_W-1:0] cnt_reg;
  logic mon_on_reg, mon_high_reg, mon_sel_reg, sw_req_reg;
  logic power_on_flag, pin_reset_flag, ext_flag_reg, sw_flag_reg, flash_flag_reg;
  logic cause_pin_reg, cause_ext_reg, cause_sw_reg, cause_flash_reg;
  logic drive_pin_reg, por_first_reg, core_rst_d_reg, wr_pend_reg;
  logic [7:0] wr_addr_reg, supply_monitor_ctrl, reset_cause_reg;
  logic [31:0] rdata_reg;
  logic src_pin, src_mon, src_flash, src_any, src_hold, addr_phase;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = ((addr & `RSC_OFF_MASK) == off);
  endfunction

  // ------------------------------------------------------------------
  // Reset sources
  // ------------------------------------------------------------------
  assign src_pin = ~rst_pin_i & ~drive_pin_reg;
  assign src_mon = mon_on_reg & mon_sel_reg & ~supply_above;
  assign src_flash = flash_op & ~(mon_on_reg & mon_high_reg);
  assign src_any = src_pin | src_mon | src_flash | sw_req_reg | ext_rst_req;
  assign src_hold = src_pin | src_mon | ext_rst_req;

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      rsc_pkg::RSC_POR_WAIT:
        if (supply_above)
          state_next = rsc_pkg::RSC_POR_DELAY;
      rsc_pkg::RSC_POR_DELAY:
        if (!supply_above)
          state_next = rsc_pkg::RSC_POR_WAIT;
        else if (cnt_reg == POR_LAST)
          state_next = rsc_pkg::RSC_RUN;
      rsc_pkg::RSC_RUN:
        if (src_any && mon_high_reg && reg_uncal_low)
          state_next = rsc_pkg::RSC_LOCK;
        else if (src_any)
          state_next = rsc_pkg::RSC_HOLD;
      rsc_pkg::RSC_HOLD:
        if (!src_hold)
          state_next = rsc_pkg::RSC_RUN;
      rsc_pkg::RSC_LOCK:
        state_next = rsc_pkg::RSC_LOCK;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= rsc_pkg::RSC_POR_WAIT;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_reg <= '0;
    else if (state_reg == rsc_pkg::RSC_POR_DELAY)
      cnt_reg <= cnt_reg + `RSC_CNT_W'(1);
    else
      cnt_reg <= '0;
  end

  // ------------------------------------------------------------------
  // Reset pin drive and calibration trigger
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      drive_pin_reg <= 1'b1;
    else
      drive_pin_reg <= (state_next != rsc_pkg::RSC_RUN) &&
                       ((state_next != rsc_pkg::RSC_HOLD) || src_mon);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      por_first_reg <= 1'b1;
      reg_cal_start <= 1'b0;
    end
    else
    begin
      por_first_reg <= 1'b0;
      reg_cal_start <= por_first_reg || ((state_reg == rsc_pkg::RSC_RUN) && src_any);
    end
  end

  assign rst_pin_o = 1'b0;
  assign rst_pin_oe_n = ~drive_pin_reg;

  // ------------------------------------------------------------------
  // Cause capture and flags
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cause_pin_reg <= 1'b0;
      cause_ext_reg <= 1'b0;
      cause_sw_reg <= 1'b0;
      cause_flash_reg <= 1'b0;
    end
    else if (state_reg == rsc_pkg::RSC_RUN)
    begin
      cause_pin_reg <= src_pin;
      cause_ext_reg <= ext_rst_req;
      cause_sw_reg <= sw_req_reg;
      cause_flash_reg <= src_flash;
    end
    else if (state_reg == rsc_pkg::RSC_HOLD)
    begin
      cause_pin_reg <= cause_pin_reg | src_pin;
      cause_ext_reg <= cause_ext_reg | ext_rst_req;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      power_on_flag <= 1'b0;
      pin_reset_flag <= 1'b0;
      ext_flag_reg <= 1'b0;
      sw_flag_reg <= 1'b0;
      flash_flag_reg <= 1'b0;
    end
    else if ((state_reg == rsc_pkg::RSC_POR_DELAY) && (state_next == rsc_pkg::RSC_RUN))
    begin
      power_on_flag <= 1'b1;
      pin_reset_flag <= 1'b0;
      ext_flag_reg <= 1'b0;
      sw_flag_reg <= 1'b0;
      flash_flag_reg <= 1'b0;
    end
    else if ((state_reg == rsc_pkg::RSC_HOLD) && (state_next == rsc_pkg::RSC_RUN))
    begin
      power_on_flag <= 1'b0;
      pin_reset_flag <= cause_pin_reg;
      ext_flag_reg <= cause_ext_reg;
      sw_flag_reg <= cause_sw_reg;
      flash_flag_reg <= cause_flash_reg;
    end
  end

  // ------------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------------
  assign addr_phase = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  assign supply_monitor_ctrl = {mon_on_reg, supply_above, mon_high_reg, 5'h00};
  assign reset_cause_reg = {1'b0, flash_flag_reg, 1'b0, sw_flag_reg, 1'b0,
                            ext_flag_reg, power_on_flag, pin_reset_flag};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg <= `RSC_WORD_ZERO;
    end
    else
    begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase)
        wr_addr_reg <= haddr[7:0];
      if (addr_phase && !hwrite && reg_hit(haddr[7:0], `RSC_OFF_MON_CTRL))
        rdata_reg <= {24'h000000, supply_monitor_ctrl};
      else if (addr_phase && !hwrite && reg_hit(haddr[7:0], `RSC_OFF_CAUSE))
        rdata_reg <= {24'h000000, reset_cause_reg};
      else if (addr_phase)
        rdata_reg <= `RSC_WORD_ZERO;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mon_on_reg <= `RSC_MON_ON_RST;
      mon_high_reg <= `RSC_MON_HIGH_RST;
      mon_sel_reg <= `RSC_MON_SEL_RST;
    end
    else if (wr_pend_reg && reg_hit(wr_addr_reg, `RSC_OFF_MON_CTRL))
    begin
      mon_on_reg <= hwdata[`RSC_MON_ON_BIT];
      mon_high_reg <= hwdata[`RSC_MON_HIGH_BIT];
    end
    else if (wr_pend_reg && reg_hit(wr_addr_reg, `RSC_OFF_CAUSE))
      mon_sel_reg <= hwdata[`RSC_CAUSE_POR_BIT];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sw_req_reg <= 1'b0;
    else if (wr_pend_reg && reg_hit(wr_addr_reg, `RSC_OFF_CAUSE) && hwdata[`RSC_CAUSE_SW_BIT])
      sw_req_reg <= 1'b1;
    else if (state_reg != rsc_pkg::RSC_RUN)
      sw_req_reg <= 1'b0;
  end

  assign supply_monitor_on = mon_on_reg;
  assign supply_threshold_high = mon_high_reg;

  // ------------------------------------------------------------------
  // Core reset and its side effects
  // ------------------------------------------------------------------
  rsc_rst_sync u_rst_sync
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .rst_req(state_reg != rsc_pkg::RSC_RUN),
    .rst_n_out(core_rst_n)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      core_rst_d_reg <= 1'b0;
      core_halt <= 1'b1;
      sfr_load <= 1'b1;
      int_timer_off <= 1'b1;
      sp_reload <= 1'b1;
      port_latch <= `RSC_PORT_LATCH_RST;
      port_open_drain <= 1'b1;
    end
    else
    begin
      core_rst_d_reg <= core_rst_n;
      core_halt <= ~core_rst_n;
      sfr_load <= ~core_rst_n;
      int_timer_off <= ~core_rst_n;
      sp_reload <= ~core_rst_n;
      if (!core_rst_n)
      begin
        port_latch <= `RSC_PORT_LATCH_RST;
        port_open_drain <= 1'b1;
      end
    end
  end

  assign weak_pullup_en = 1'b1;
  assign ram_keep = 1'b1;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pc_clear <= 1'b0;
      pc_value <= `RSC_PC_RST;
      clk_sel_int <= 1'b1;
      wdt_en <= 1'b0;
      wdt_div <= `RSC_WDT_DIV;
    end
    else if (core_rst_n && !core_rst_d_reg)
    begin
      pc_clear <= 1'b1;
      pc_value <= `RSC_PC_RST;
      clk_sel_int <= 1'b1;
      wdt_en <= 1'b1;
      wdt_div <= `RSC_WDT_DIV;
    end
    else
    begin
      pc_clear <= 1'b0;
      if (!core_rst_n)
        wdt_en <= 1'b0;
    end
  end

endmodule // rsc_reset_source_controller

// File: dv/rsc_assertions.sv
// Port checker for the reset source controller
`timescale 1ns/1ps

module rsc_assertions
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Reset sources
  input wire logic supply_above,
  input wire logic reg_uncal_low,
  input wire logic ext_rst_req,
  input wire logic flash_op,
  input wire logic rst_pin_i,
  // Monitor, regulator and pin
  input wire logic supply_monitor_on,
  input wire logic supply_threshold_high,
  input wire logic reg_cal_start,
  input wire logic rst_pin_oe_n,
  // Core side
  input wire logic core_rst_n,
  input wire logic core_halt,
  input wire logic sfr_load,
  input wire logic int_timer_off,
  input wire logic sp_reload,
  input wire logic ram_keep,
  input wire logic [7:0] port_latch,
  input wire logic port_open_drain,
  input wire logic weak_pullup_en,
  input wire logic pc_clear,
  input wire logic [15:0] pc_value,
  input wire logic clk_sel_int,
  input wire logic wdt_en,
  input wire logic [3:0] wdt_div
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----
  // Sequences
  // ----
  sequence s_dip;
    core_rst_n && supply_monitor_on && !supply_above ##1 !supply_above [*2] ##1 supply_above;
  endsequence
  sequence s_trip;
    core_rst_n && (ext_rst_req || !rst_pin_i
      || flash_op && !(supply_monitor_on && supply_threshold_high));
  endsequence
  sequence s_exit;
    ##1 pc_clear && wdt_en && clk_sel_int && pc_value == 16'h0000 && wdt_div == 4'hc
      ##1 !pc_clear;
  endsequence

  // ----
  // Properties
  // ----
  property p_quiet;
    (core_halt && sfr_load && int_timer_off && sp_reload) == !$past(core_rst_n);
  endproperty
  property p_port;
    !$past(core_rst_n) |-> port_latch == 8'hff && port_open_drain && ram_keep && weak_pullup_en;
  endproperty
  property p_exit;
    $rose(core_rst_n) |-> s_exit;
  endproperty
  property p_pin;
    !supply_above && supply_monitor_on |=> !rst_pin_oe_n;
  endproperty
  property p_no_delay;
    s_dip |-> ##[1:6] core_rst_n;
  endproperty
  property p_cal;
    $fell(core_rst_n) |-> $past(reg_cal_start) && !reg_cal_start;
  endproperty
  property p_trip;
    s_trip |-> ##2 !core_rst_n;
  endproperty
  property p_lock;
    $fell(core_rst_n) && $past(supply_threshold_high, 2) && $past(reg_uncal_low, 2)
      |-> (!core_rst_n && !rst_pin_oe_n) [*8];
  endproperty

  a_quiet: assert property (p_quiet) else $error("core not held quiet");
  a_port: assert property (p_port) else $error("port state wrong in reset");
  a_exit: assert property (p_exit) else $error("exit state wrong");
  a_pin: assert property (p_pin) else $error("pin not driven");
  a_no_delay: assert property (p_no_delay) else $error("slow monitor release");
  a_cal: assert property (p_cal) else $error("no calibration pulse");
  a_trip: assert property (p_trip) else $error("source ignored");
  a_lock: assert property (p_lock) else $error("lock released");
endmodule // rsc_assertions

bind rsc_reset_source_controller rsc_assertions rsc_assertions_inst (.*);

// File: dv/rsc_supply_model.sv
// Supply comparator and open-drain reset pin model
`timescale 1ns/1ps

module rsc_supply_model
(
  // Bench stimulus
  input wire logic vdd_ok,
  input wire logic pin_press,
  // Device side
  input wire logic supply_monitor_on,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe_n,
  output logic supply_above,
  output logic rst_pin_i
);
  // Unpowered comparator reports low
  assign supply_above = supply_monitor_on && vdd_ok;
  // Pulled-up wire, low if either party pulls
  assign rst_pin_i = !(pin_press || (!rst_pin_oe_n && !rst_pin_o));
endmodule // rsc_supply_model

// File: dv/rsc_reset_source_controller_bench.sv
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
`include "rsc_cfg.svh"

module rsc_reset_source_controller_bench;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, supply_above, reg_uncal_low = 1'h0, supply_monitor_on;
  logic supply_threshold_high, reg_cal_start, ext_rst_req = 1'h0, flash_op = 1'h0;
  logic rst_pin_i, rst_pin_o, rst_pin_oe_n, core_rst_n, core_halt, sfr_load, int_timer_off;
  logic sp_reload, ram_keep, port_open_drain, weak_pullup_en, pc_clear, clk_sel_int, wdt_en;
  logic vdd_ok = 1'h0, pin_press = 1'h0;
  logic [7:0] port_latch;
  logic [15:0] pc_value;
  logic [3:0] wdt_div;
  logic [31:0] cause_exp [4] = '{32'h1, 32'h4, 32'h10, 32'h40};
  int miscompares = 0, total_checks = 0, n;

  always #50 hclk = ~hclk;
  assign hready = hreadyout;

  rsc_reset_source_controller rsc_reset_source_controller_inst (.*);
  rsc_supply_model rsc_supply_model_inst (.*);

  // ----
  // Tasks
  // ----
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string w, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", w, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge hclk);
  endtask

  task automatic hang();
    miscompares++;
    give_verdict();
  endtask

  task automatic wait_ready();
    tick(1);
    for (n = 0; hready !== 1'h1; n++)
    begin
      if (n == 50)
        hang();
      tick(1);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic rdchk(input string w, input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(w, rd, exp);
  endtask

  task automatic wait_core(input logic lvl, input int lim);
    for (n = 0; core_rst_n !== lvl; n++)
    begin
      if (n == lim)
        hang();
      tick(1);
    end
  endtask

  task automatic por();
    hresetn <= 1'h0;
    tick(3);
    hresetn <= 1'h1;
  endtask

  // ----
  // Scenarios
  // ----
  initial
  begin
    por();
    tick(2);
    chk("cal", reg_cal_start, 32'h1);
    chk("pin_oe_n", rst_pin_oe_n, 32'h0);
    chk("quiet", {core_halt, sfr_load, int_timer_off, sp_reload, ram_keep, weak_pullup_en,
      port_open_drain}, 32'h7f);
    chk("latch", port_latch, {24'h0, `RSC_PORT_LATCH_RST});
    tick(20);
    chk("por_hold", core_rst_n, 32'h0);
    vdd_ok <= 1'h1;
    wait_core(1'h1, 1200);
    chk("por_delay", n >= `RSC_POR_DELAY_CYC && n <= `RSC_POR_DELAY_CYC + 8, 32'h1);
    tick(1);
    chk("exit", {pc_clear, wdt_en, clk_sel_int, wdt_div, pc_value},
      {3'h7, `RSC_WDT_DIV, `RSC_PC_RST});
    rdchk("ctrl", `RSC_OFF_MON_CTRL, 32'hc0);
    chk("mon_pins", {hresp, supply_monitor_on, supply_threshold_high, rst_pin_o}, 32'h4);
    rdchk("cause", `RSC_OFF_CAUSE, 32'h2);
    bus(1'h1, 8'h80, 32'hffff_ffff);
    rdchk("unmapped", 8'h80, 32'h0);
    rdchk("ctrl_kept", `RSC_OFF_MON_CTRL, 32'hc0);
    vdd_ok <= 1'h0;
    tick(2);
    chk("dip_pin", rst_pin_oe_n, 32'h0);
    tick(1);
    vdd_ok <= 1'h1;
    wait_core(1'h1, 20);
    chk("dip_fast", n < 10, 32'h1);
    rdchk("dip_cause", `RSC_OFF_CAUSE, 32'h0);
    bus(1'h1, `RSC_OFF_MON_CTRL, 32'h0);
    for (int k = 0; k < 4; k++)
    begin
      case (k)
        0: pin_press <= 1'h1;
        1: ext_rst_req <= 1'h1;
        2: bus(1'h1, `RSC_OFF_CAUSE, 32'h12);
        default: flash_op <= 1'h1;
      endcase
      tick(1);
      pin_press <= 1'h0;
      ext_rst_req <= 1'h0;
      flash_op <= 1'h0;
      wait_core(1'h0, 10);
      wait_core(1'h1, 20);
      rdchk("src_cause", `RSC_OFF_CAUSE, cause_exp[k]);
    end
    rdchk("mon_off_kept", `RSC_OFF_MON_CTRL, 32'h0);
    bus(1'h1, `RSC_OFF_MON_CTRL, 32'ha0);
    bus(1'h1, `RSC_OFF_CAUSE, 32'h2);
    flash_op <= 1'h1;
    tick(1);
    flash_op <= 1'h0;
    tick(5);
    chk("armed_flash", core_rst_n, 32'h1);
    rdchk("ctrl_high", `RSC_OFF_MON_CTRL, 32'he0);
    chk("mon_pins_high", {hresp, supply_monitor_on, supply_threshold_high}, 32'h3);
    reg_uncal_low <= 1'h1;
    ext_rst_req <= 1'h1;
    tick(1);
    ext_rst_req <= 1'h0;
    tick(30);
    chk("lock", {core_rst_n, rst_pin_oe_n}, 32'h0);
    reg_uncal_low <= 1'h0;
    tick(1);
    por();
    wait_core(1'h1, 1200);
    rdchk("ctrl_low", `RSC_OFF_MON_CTRL, 32'hc0);
    give_verdict();
  end
endmodule // rsc_reset_source_controller_bench
